// ---- spx_page_ext.v ----
// sram page extension: page selection, stack pointer, indirect move sequencing, apb registers
// assumes sram read data is valid the second cycle after mem_valid_ff rises with mem_write_ff low
`timescale 1ns/1ps
`default_nettype none
`include "spx_regs.vh"
module spx_page_ext #(
    parameter PAGE_W = 3
) (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    input wire acc_valid,
    input wire [2:0] acc_kind,
    input wire acc_write,
    input wire [7:0] acc_addr,
    input wire [7:0] acc_wdata,
    output reg acc_ready_ff,
    output reg acc_done_ff,
    output reg [7:0] acc_rdata_ff,
    output reg mem_valid_ff,
    output reg mem_write_ff,
    output reg [PAGE_W+7:0] mem_addr_ff,
    output reg [7:0] mem_wdata_ff,
    input wire [7:0] mem_rdata
);

localparam S_IDLE = 3'h0;
localparam S_MP1 = 3'h1;
localparam S_MP2 = 3'h2;
localparam S_MV = 3'h3;
localparam S_RD1 = 3'h4;
localparam S_RD2 = 3'h5;
localparam S_PW = 3'h6;

reg [PAGE_W-1:0] current_page_pointer_ff;
reg [PAGE_W-1:0] stack_page_pointer_ff;
reg [PAGE_W-1:0] index_page_pointer_ff;
reg [PAGE_W-1:0] move_read_page_pointer_ff;
reg [PAGE_W-1:0] move_write_page_pointer_ff;
reg [7:0] flags_ff;
reg [7:0] stack_pointer_register_ff;
reg [2:0] state_ff;
reg [2:0] op_ff;
reg [7:0] ptr_ff;
reg [7:0] wdata_ff;
reg [7:0] nxt_flags;
reg [7:0] nxt_sp;

wire [1:0] page_mode_bits = flags_ff[`SPX_FLG_MODE_HI:`SPX_FLG_MODE_LO];
wire [7:0] reg_idx = paddr[9:2];
wire apb_setup = psel & ~penable;
wire apb_wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;

// page for normal accesses and move pointer accesses
function [PAGE_W-1:0] normal_page;
    input [1:0] mode;
    input [PAGE_W-1:0] cur;
    begin
        normal_page = mode[1] ? cur : {PAGE_W{1'b0}};
    end
endfunction

// register index decode
function reg_hit;
    input [7:0] idx;
    begin
        if (idx == `SPX_IDX_CUR) reg_hit = 1'b1;
        else if (idx == `SPX_IDX_STK) reg_hit = 1'b1;
        else if (idx == `SPX_IDX_IDX) reg_hit = 1'b1;
        else if (idx == `SPX_IDX_MVR) reg_hit = 1'b1;
        else if (idx == `SPX_IDX_MVW) reg_hit = 1'b1;
        else if (idx == `SPX_IDX_FLG) reg_hit = 1'b1;
        else if (idx == `SPX_IDX_SP) reg_hit = 1'b1;
        else reg_hit = 1'b0;
    end
endfunction

reg [PAGE_W-1:0] idx_page;
always @* begin
    case (page_mode_bits)
        2'b00: idx_page = {PAGE_W{1'b0}};
        2'b10: idx_page = index_page_pointer_ff;
        default: idx_page = stack_page_pointer_ff;
    endcase
end

// value of the addressed register, reserved bits read zero
reg [31:0] reg_rdata;
always @* begin
    reg_rdata = 32'h0;
    if (reg_idx == `SPX_IDX_CUR) reg_rdata[PAGE_W-1:0] = current_page_pointer_ff;
    else if (reg_idx == `SPX_IDX_STK) reg_rdata[PAGE_W-1:0] = stack_page_pointer_ff;
    else if (reg_idx == `SPX_IDX_IDX) reg_rdata[PAGE_W-1:0] = index_page_pointer_ff;
    else if (reg_idx == `SPX_IDX_MVR) reg_rdata[PAGE_W-1:0] = move_read_page_pointer_ff;
    else if (reg_idx == `SPX_IDX_MVW) reg_rdata[PAGE_W-1:0] = move_write_page_pointer_ff;
    else if (reg_idx == `SPX_IDX_FLG) reg_rdata[7:0] = flags_ff;
    else if (reg_idx == `SPX_IDX_SP) reg_rdata[7:0] = stack_pointer_register_ff;
end

wire [PAGE_W-1:0] cur_page = normal_page(page_mode_bits, current_page_pointer_ff);
wire start = (state_ff == S_IDLE) & acc_valid;
wire [7:0] sp_dec = stack_pointer_register_ff - 8'h01;
wire [7:0] sp_inc = stack_pointer_register_ff + 8'h01;
wire [7:0] ptr_inc = mem_rdata + 8'h01;

// address, direction, data and follow-on state of a newly taken access
reg [PAGE_W+7:0] nxt_addr;
reg nxt_write;
reg [7:0] nxt_wdata;
reg [2:0] nxt_state;
always @* begin
    nxt_addr = {cur_page, acc_addr};
    nxt_write = 1'b0;
    nxt_wdata = acc_wdata;
    nxt_state = S_RD1;
    case (acc_kind)
        `SPX_K_NORMAL: begin
            nxt_addr = {cur_page, acc_addr};
            nxt_write = acc_write;
            if (acc_write) nxt_state = S_MV;
        end
        `SPX_K_INDEXED: begin
            nxt_addr = {idx_page, acc_addr};
            nxt_write = acc_write;
            if (acc_write) nxt_state = S_MV;
        end
        `SPX_K_PUSH: begin
            nxt_addr = {stack_page_pointer_ff, stack_pointer_register_ff};
            nxt_write = 1'b1;
            nxt_state = S_MV;
        end
        `SPX_K_IRQ: begin
            nxt_addr = {stack_page_pointer_ff, stack_pointer_register_ff};
            nxt_write = 1'b1;
            nxt_wdata = flags_ff;
            nxt_state = S_MV;
        end
        `SPX_K_POP,
        `SPX_K_INTERRUPT_RETURN_INSTRUCTION: nxt_addr = {stack_page_pointer_ff, sp_dec};
        default: begin
            nxt_addr = {cur_page, acc_addr};
            nxt_state = S_MP1;
        end
    endcase
end

// flags and stack pointer: core events win over apb writes
always @* begin
    nxt_flags = flags_ff;
    nxt_sp = stack_pointer_register_ff;
    if (apb_wr && reg_idx == `SPX_IDX_FLG) nxt_flags = pwdata[7:0];
    if (apb_wr && reg_idx == `SPX_IDX_SP) nxt_sp = pwdata[7:0];
    if (start) begin
        case (acc_kind)
            `SPX_K_PUSH: nxt_sp = sp_inc;
            `SPX_K_IRQ: begin
                nxt_sp = sp_inc;
                nxt_flags = `SPX_FLG_RST;
            end
            `SPX_K_POP: nxt_sp = sp_dec;
            `SPX_K_INTERRUPT_RETURN_INSTRUCTION: nxt_sp = sp_dec;
            default: nxt_sp = nxt_sp;
        endcase
    end
    if (state_ff == S_RD2 && op_ff == `SPX_K_INTERRUPT_RETURN_INSTRUCTION) nxt_flags = mem_rdata;
end

// pointer registers and apb answer
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        current_page_pointer_ff <= `SPX_PG_RST;
        stack_page_pointer_ff <= `SPX_PG_RST;
        index_page_pointer_ff <= `SPX_PG_RST;
        move_read_page_pointer_ff <= `SPX_PG_RST;
        move_write_page_pointer_ff <= `SPX_PG_RST;
        flags_ff <= `SPX_FLG_RST;
        stack_pointer_register_ff <= `SPX_SP_RST;
        prdata_ff <= 32'h0;
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
    end else begin
        flags_ff <= nxt_flags;
        stack_pointer_register_ff <= nxt_sp;
        pready_ff <= apb_setup;
        pslverr_ff <= apb_setup & ~reg_hit(reg_idx);
        if (apb_wr) begin
            if (reg_idx == `SPX_IDX_CUR) current_page_pointer_ff <= pwdata[PAGE_W-1:0];
            else if (reg_idx == `SPX_IDX_STK) stack_page_pointer_ff <= pwdata[PAGE_W-1:0];
            else if (reg_idx == `SPX_IDX_IDX) index_page_pointer_ff <= pwdata[PAGE_W-1:0];
            else if (reg_idx == `SPX_IDX_MVR) move_read_page_pointer_ff <= pwdata[PAGE_W-1:0];
            else if (reg_idx == `SPX_IDX_MVW) move_write_page_pointer_ff <= pwdata[PAGE_W-1:0];
        end
        prdata_ff <= (apb_setup && !pwrite) ? reg_rdata : 32'h0;
    end
end

// access sequencer toward the sram
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        state_ff <= S_IDLE;
        op_ff <= `SPX_K_NORMAL;
        ptr_ff <= 8'h00;
        wdata_ff <= 8'h00;
        acc_ready_ff <= 1'b0;
        acc_done_ff <= 1'b0;
        acc_rdata_ff <= 8'h00;
        mem_valid_ff <= 1'b0;
        mem_write_ff <= 1'b0;
        mem_addr_ff <= {(PAGE_W+8){1'b0}};
        mem_wdata_ff <= 8'h00;
    end else begin
        mem_valid_ff <= 1'b0;
        acc_done_ff <= 1'b0;
        acc_ready_ff <= 1'b0;
        case (state_ff)
            S_IDLE: begin
                acc_ready_ff <= ~acc_valid;
                if (acc_valid) begin
                    op_ff <= acc_kind;
                    wdata_ff <= acc_wdata;
                    mem_valid_ff <= 1'b1;
                    mem_write_ff <= nxt_write;
                    mem_addr_ff <= nxt_addr;
                    mem_wdata_ff <= nxt_wdata;
                    state_ff <= nxt_state;
                end
            end
            S_MP1: state_ff <= S_MP2;
            S_MP2: begin
                ptr_ff <= mem_rdata;
                mem_valid_ff <= 1'b1;
                mem_write_ff <= 1'b1;
                mem_wdata_ff <= ptr_inc;
                state_ff <= S_PW;
            end
            // move data access uses the pointer as read, before its increment
            S_PW: begin
                mem_valid_ff <= 1'b1;
                mem_wdata_ff <= wdata_ff;
                if (op_ff == `SPX_K_MVI_RD) begin
                    mem_addr_ff <= {move_read_page_pointer_ff, ptr_ff};
                    mem_write_ff <= 1'b0;
                    state_ff <= S_RD1;
                end else begin
                    mem_addr_ff <= {move_write_page_pointer_ff, ptr_ff};
                    mem_write_ff <= 1'b1;
                    state_ff <= S_MV;
                end
            end
            S_MV: begin
                acc_done_ff <= 1'b1;
                acc_ready_ff <= 1'b1;
                state_ff <= S_IDLE;
            end
            S_RD1: state_ff <= S_RD2;
            S_RD2: begin
                acc_rdata_ff <= mem_rdata;
                acc_done_ff <= 1'b1;
                acc_ready_ff <= 1'b1;
                state_ff <= S_IDLE;
            end
            default: state_ff <= S_IDLE;
        endcase
    end
end

endmodule // spx_page_ext
`default_nettype wire

// ---- spx_regs.vh ----
// constants of the sram page extension block
// assumes a 32-bit apb slave, register byte address = index * 4
`ifndef SPX_REGS_VH
`define SPX_REGS_VH
`define SPX_IDX_CUR 8'hd0
`define SPX_IDX_STK 8'hd1
`define SPX_IDX_IDX 8'hd3
`define SPX_IDX_MVR 8'hd4
`define SPX_IDX_MVW 8'hd5
`define SPX_IDX_FLG 8'hd8
`define SPX_IDX_SP 8'hd9
`define SPX_PG_RST 3'h0
`define SPX_FLG_RST 8'h00
`define SPX_SP_RST 8'h00
`define SPX_FLG_MODE_HI 7
`define SPX_FLG_MODE_LO 6
`define SPX_K_NORMAL 3'h0
`define SPX_K_INDEXED 3'h1
`define SPX_K_PUSH 3'h2
`define SPX_K_POP 3'h3
`define SPX_K_MVI_RD 3'h4
`define SPX_K_MVI_WR 3'h5
`define SPX_K_IRQ 3'h6
`define SPX_K_INTERRUPT_RETURN_INSTRUCTION 3'h7
`endif

// ---- spx_sram_mdl.sv ----
// paged sram model on the far side of spx_page_ext
// assumes read data is wanted in the cycle right after a read strobe on mem_valid_ff
`timescale 1ns/1ps
`default_nettype none
module spx_sram_mdl (
    input wire logic clk_sys,
    input wire logic mem_valid_ff,
    input wire logic mem_write_ff,
    input wire logic [10:0] mem_addr_ff,
    input wire logic [7:0] mem_wdata_ff,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:2047];
    initial mem_rdata = 8'h5a;
    always @(posedge clk_sys) begin
        if (mem_valid_ff && mem_write_ff) begin
            mem[mem_addr_ff] <= mem_wdata_ff;
        end
        if (mem_valid_ff && !mem_write_ff) begin
            mem_rdata <= mem[mem_addr_ff];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // spx_sram_mdl
`default_nettype wire

// ---- spx_page_ext_properties.sv ----
// checker for spx_page_ext apb answers and core access sequencing
// assumes it is bound onto spx_page_ext and only watches its ports
`timescale 1ns/1ps
`default_nettype none
`include "spx_regs.vh"
module spx_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready_ff,
    input wire logic pslverr_ff,
    input wire logic acc_valid,
    input wire logic [2:0] acc_kind,
    input wire logic acc_write,
    input wire logic acc_ready_ff,
    input wire logic acc_done_ff,
    input wire logic mem_valid_ff,
    input wire logic mem_write_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire tk = acc_valid && acc_ready_ff;
    a_apb_answer: assert property (psel && !penable |=> pready_ff) else $error("no apb answer");
    a_apb_single: assert property (pready_ff |=> !pready_ff) else $error("ready too long");
    a_err_ready: assert property (pslverr_ff |-> pready_ff) else $error("error without ready");
    a_write_done: assert property (tk && acc_kind == `SPX_K_NORMAL && acc_write |-> ##2 acc_done_ff)
        else $error("write late");
    a_push_write: assert property (tk && acc_kind == `SPX_K_PUSH |=> mem_valid_ff && mem_write_ff ##1 acc_done_ff)
        else $error("push wrong");
    a_irq_push: assert property (tk && acc_kind == `SPX_K_IRQ |=> mem_valid_ff && mem_write_ff ##1 acc_done_ff)
        else $error("irq push wrong");
    a_interrupt_return_instruction_read: assert property (tk && acc_kind == `SPX_K_INTERRUPT_RETURN_INSTRUCTION |=> mem_valid_ff && !mem_write_ff ##2 acc_done_ff)
        else $error("return wrong");
    a_move_steps: assert property (tk && acc_kind == `SPX_K_MVI_RD |=> mem_valid_ff && !mem_write_ff
        ##2 mem_valid_ff && mem_write_ff ##1 mem_valid_ff && !mem_write_ff ##2 acc_done_ff)
        else $error("move steps wrong");
    a_done_pulse: assert property (acc_done_ff |=> !acc_done_ff) else $error("done too long");
    c_move: cover property (tk && acc_kind == `SPX_K_MVI_RD);
    c_interrupt_return_instruction: cover property (tk && acc_kind == `SPX_K_INTERRUPT_RETURN_INSTRUCTION);
    c_err: cover property (pslverr_ff);
endmodule // spx_chk
bind spx_page_ext spx_chk spx_chk_i (.*);
`default_nettype wire

// ---- tb_top.sv ----
// bench for spx_page_ext: apb registers and paged core accesses
// assumes spx_sram_mdl answers reads in the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
`include "spx_regs.vh"
module tb_top;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready_ff, pslverr_ff, er;
    logic acc_valid = 0, acc_write = 0, acc_ready_ff, acc_done_ff, mem_valid_ff, mem_write_ff;
    logic [2:0] acc_kind = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata_ff, rd;
    logic [7:0] acc_addr = 0, acc_wdata = 0, acc_rdata_ff, mem_wdata_ff, mem_rdata, r8;
    logic [10:0] mem_addr_ff;
    int n_errors = 0, tests_run = 0, cyc = 0;
    spx_page_ext spx_page_ext_i (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_write(acc_write), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_ready_ff(acc_ready_ff), .acc_done_ff(acc_done_ff),
        .acc_rdata_ff(acc_rdata_ff), .mem_valid_ff(mem_valid_ff), .mem_write_ff(mem_write_ff),
        .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata)
    );
    spx_sram_mdl spx_sram_mdl_i (
        .clk_sys(clk_sys), .mem_valid_ff(mem_valid_ff), .mem_write_ff(mem_write_ff),
        .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata)
    );
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            test_done;
        end
    end
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do begin
            @(posedge clk_sys);
        end while (pready_ff !== 1'b1);
        rd = prdata_ff;
        er = pslverr_ff;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic acc(input logic [2:0] k, input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk_sys);
        acc_valid <= 1;
        acc_kind <= k;
        acc_write <= w;
        acc_addr <= a;
        acc_wdata <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (acc_ready_ff !== 1'b1 && n < 20);
        acc_valid <= 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (acc_done_ff !== 1'b1 && n < 40);
        r8 = acc_rdata_ff;
        chk(n < 40, 1);
    endtask
    function automatic logic [7:0] m(input logic [2:0] p, input logic [7:0] a);
        return spx_sram_mdl_i.mem[{p, a}];
    endfunction
    task automatic t_reset;
        logic [7:0] ix [7] = '{`SPX_IDX_CUR, `SPX_IDX_STK, `SPX_IDX_IDX, `SPX_IDX_MVR, `SPX_IDX_MVW,
            `SPX_IDX_FLG, `SPX_IDX_SP};
        foreach (ix[i]) begin
            apb(0, ix[i], 0);
            chk(rd, 0);
        end
        apb(0, 8'h00, 0);
        chk(er, 1);
        apb(1, `SPX_IDX_CUR, 32'hff);
        apb(0, `SPX_IDX_CUR, 0);
        chk(rd, 7);
    endtask
    task automatic t_normal;
        logic [7:0] fl [3] = '{8'h00, 8'h40, 8'h80};
        logic [2:0] pg [3] = '{3'h0, 3'h0, 3'h5};
        apb(1, `SPX_IDX_CUR, 5);
        foreach (fl[i]) begin
            apb(1, `SPX_IDX_FLG, fl[i]);
            acc(`SPX_K_NORMAL, 1, 8'h10 + i, 8'ha0 + i);
            chk(m(pg[i], 8'h10 + i), 8'ha0 + i);
        end
        acc(`SPX_K_NORMAL, 0, 8'h12, 0);
        chk(r8, 8'ha2);
    endtask
    task automatic t_indexed;
        logic [2:0] ip [4] = '{3'h0, 3'h3, 3'h6, 3'h3};
        apb(1, `SPX_IDX_STK, 3);
        apb(1, `SPX_IDX_IDX, 6);
        for (int i = 0; i < 4; i++) begin
            apb(1, `SPX_IDX_FLG, {i[1:0], 6'h00});
            acc(`SPX_K_INDEXED, 1, 8'h20 + i, 8'h50 + i);
            chk(m(ip[i], 8'h20 + i), 8'h50 + i);
        end
    endtask
    task automatic t_stack;
        apb(1, `SPX_IDX_FLG, 8'h80);
        apb(1, `SPX_IDX_SP, 8'hff);
        acc(`SPX_K_PUSH, 0, 0, 8'h5c);
        chk(m(3, 8'hff), 8'h5c);
        apb(0, `SPX_IDX_SP, 0);
        chk(rd, 0);
        acc(`SPX_K_NORMAL, 1, 8'h40, 8'h33);
        chk(m(5, 8'h40), 8'h33);
        acc(`SPX_K_POP, 0, 0, 0);
        chk(r8, 8'h5c);
        apb(0, `SPX_IDX_SP, 0);
        chk(rd, 8'hff);
    endtask
    task automatic t_irq;
        apb(1, `SPX_IDX_FLG, 8'hc0);
        acc(`SPX_K_IRQ, 0, 0, 0);
        chk(m(3, 8'hff), 8'hc0);
        apb(0, `SPX_IDX_FLG, 0);
        chk(rd, 0);
        acc(`SPX_K_NORMAL, 1, 8'h41, 8'h44);
        chk(m(0, 8'h41), 8'h44);
        apb(1, `SPX_IDX_CUR, 1);
        apb(1, `SPX_IDX_FLG, 8'h40);
        apb(1, `SPX_IDX_CUR, 5);
        acc(`SPX_K_INTERRUPT_RETURN_INSTRUCTION, 0, 0, 0);
        apb(0, `SPX_IDX_FLG, 0);
        chk(rd, 8'hc0);
        acc(`SPX_K_NORMAL, 1, 8'h42, 8'h45);
        chk(m(5, 8'h42), 8'h45);
    endtask
    task automatic t_move;
        apb(1, `SPX_IDX_FLG, 8'h80);
        apb(1, `SPX_IDX_MVR, 2);
        apb(1, `SPX_IDX_MVW, 4);
        acc(`SPX_K_NORMAL, 1, 8'h30, 8'h60);
        acc(`SPX_K_MVI_WR, 0, 8'h30, 8'h77);
        chk(m(4, 8'h60), 8'h77);
        chk(m(5, 8'h30), 8'h61);
        spx_sram_mdl_i.mem[{3'h2, 8'h61}] = 8'h9e;
        acc(`SPX_K_MVI_RD, 0, 8'h30, 0);
        chk(r8, 8'h9e);
        chk(m(5, 8'h30), 8'h62);
        apb(1, `SPX_IDX_FLG, 0);
        acc(`SPX_K_NORMAL, 1, 8'h30, 8'h70);
        acc(`SPX_K_MVI_WR, 0, 8'h30, 8'h88);
        chk(m(4, 8'h70), 8'h88);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 0;
        t_reset;
        t_normal;
        t_indexed;
        t_stack;
        t_irq;
        t_move;
        test_done;
    end
endmodule // tb_top
`default_nettype wire
